// ---- design/ebi_external_bus_interface.sv ----
// Behaviour
// R01: a slow external device pulls ready low; the access then gains wait states.
// R02: while ready is low, wait one cycle and sample again until high.
// R03: ready is only sampled when at least one software wait state is programmed.
// R04: boot select low at reset: microcomputer mode, fetch internal flash at 0000h.
// R05: boot select high at reset: microprocessor mode, fetch external memory at 0000h.
// R06: boot select level at reset is captured into bit 2 of control register two.
// R07: external interface signals are enabled only while the enable pin is high.
// R08: with the enable pin low, a data space access flags an illegal address.
// R09: in visibility mode, drive indicator low while driving the data bus, else high.
// R10: external decode may use the drive indicator to release the data bus.
// R11: access address appears on a 16-bit bus, bit 0 upward.
// R12: each space strobe stays high and goes low only for its own space.
// R13: read/write qualifier rests high and goes low only during a write.
// R14: access strobe goes low for every off-chip bus cycle.
// R15: read strobe is asserted for every external read of any space.
// R16: programmed soft wait states come first, then ready extends the cycle.
// R17: the illegal address condition is reported as a single-cycle event.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`include "ebi_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ebi_external_bus_interface #(
	parameter int ADDR_W = 16,
	parameter int WS_W   = 3
) (
	input  wire logic               clk,
	input  wire logic               reset,
	// register port
	input  wire logic [3:0]         reg_addr,
	input  wire logic [15:0]        reg_wdata,
	input  wire logic               reg_write,
	input  wire logic               reg_read,
	output logic      [15:0]        reg_rdata,
	output logic                    irq,
	// core access request
	input  wire logic               acc_req,
	input  wire logic [1:0]         acc_space,
	input  wire logic               acc_write,
	input  wire logic [ADDR_W-1:0]  acc_addr,
	input  wire logic [15:0]        acc_wdata,
	input  wire logic               visibility_mode,
	output logic                    acc_busy,
	output logic                    acc_done,
	output logic      [15:0]        acc_rdata,
	output logic                    illegal_addr,
	output logic                    boot_external,
	output logic      [ADDR_W-1:0]  boot_vector,
	// pins
	input  wire logic               ready_pin,
	input  wire logic               boot_memory_select,
	input  wire logic               ext_interface_on,
	output logic      [ADDR_W-1:0]  ext_addr,
	input  wire logic [15:0]        ext_data_in,
	output logic      [15:0]        ext_data_out,
	output logic                    ext_data_oe,
	output logic                    data_space_strobe_n,
	output logic                    io_space_strobe_n,
	output logic                    program_space_strobe_n,
	output logic                    access_strobe_n,
	output logic                    read_write,
	output logic                    read_strobe_n,
	output logic                    write_strobe_n,
	output logic                    observe_mode_bus_drive_n
);

	// pin synchronisers: stage one feeds only stage two
	logic [2:0] sync1;
	logic [2:0] sync2;
	always_ff @(posedge clk) begin
		sync1 <= {ready_pin, boot_memory_select, ext_interface_on};
		sync2 <= sync1;
	end
	wire logic ready_s = sync2[2];
	wire logic boot_s  = sync2[1];
	wire logic ena_s   = sync2[0];

	// registers
	logic [15:0]     wait_state_config_reg;
	logic [15:0]     system_control_reg_two;
	logic [1:0]      status;
	logic [1:0]      mask;
	logic            boot_pending;

	ebi_pkg::ebi_state_t state;
	ebi_pkg::ebi_state_t next_state;
	logic [WS_W-1:0] ws_cnt;
	logic [1:0]      cur_space;
	logic            cur_write;

	wire logic [WS_W-1:0] soft_ws = wait_state_config_reg[WS_W-1:0];
	wire logic wr_wscfg  = reg_write && (reg_addr == `EBI_WSCFG_ADDR);
	wire logic wr_sysctl = reg_write && (reg_addr == `EBI_SYSCTL2_ADDR);
	wire logic wr_status = reg_write && (reg_addr == `EBI_STATUS_ADDR);
	wire logic wr_mask   = reg_write && (reg_addr == `EBI_MASK_ADDR);

	// a data-space access with the interface off never reaches the pins
	wire logic start_ok  = acc_req && (state == ebi_pkg::EBI_IDLE) && ena_s; // R07
	wire logic start_bad = acc_req && (state == ebi_pkg::EBI_IDLE) && !ena_s
		&& (acc_space == ebi_pkg::EBI_SPACE_DATA); // R08
	wire logic finishing = (state == ebi_pkg::EBI_END);

	// the synchroniser lags two cycles: an early sample would still show
	// the idle level of the ready pin from before the strobes fell
	logic [1:0]      acc_age;
	wire logic       ready_fresh = acc_age[1];
	always_ff @(posedge clk) begin
		if (reset || start_ok)
			acc_age <= 2'h0;
		else if (state != ebi_pkg::EBI_IDLE && !acc_age[1])
			acc_age <= acc_age + 2'h1; // R02
	end

	logic [15:0] rd_mux;
	always_comb begin
		case (reg_addr)
			`EBI_WSCFG_ADDR:   rd_mux = wait_state_config_reg;
			`EBI_SYSCTL2_ADDR: rd_mux = system_control_reg_two;
			`EBI_STATUS_ADDR:  rd_mux = {14'h0000, status};
			`EBI_MASK_ADDR:    rd_mux = {14'h0000, mask};
			default:           rd_mux = 16'h0000;
		endcase
	end

	always_comb begin
		next_state = state;
		case (state)
			ebi_pkg::EBI_IDLE: begin
				if (start_ok) begin
					if (soft_ws != '0)
						next_state = ebi_pkg::EBI_SOFT; // R16
					else
						next_state = ebi_pkg::EBI_END; // R03
				end
			end
			ebi_pkg::EBI_SOFT: begin
				if (ws_cnt == WS_W'(1))
					next_state = ebi_pkg::EBI_READY; // R16
			end
			ebi_pkg::EBI_READY: begin
				// one cycle per sample while the device holds ready low
				if (ready_s && ready_fresh)
					next_state = ebi_pkg::EBI_END; // R01 R02
			end
			ebi_pkg::EBI_END: next_state = ebi_pkg::EBI_IDLE;
			default:          next_state = ebi_pkg::EBI_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= ebi_pkg::EBI_IDLE;
			ws_cnt <= '0;
			cur_space <= 2'h0;
			cur_write <= 1'b0;
		end else begin
			state <= next_state;
			if (start_ok) begin
				ws_cnt <= soft_ws;
				cur_space <= acc_space;
				cur_write <= acc_write;
			end else if (state == ebi_pkg::EBI_SOFT) begin
				ws_cnt <= ws_cnt - WS_W'(1);
			end
		end
	end

	// pin outputs, registered; all strobes rest high
	wire logic       active    = (next_state != ebi_pkg::EBI_IDLE);
	wire logic       pins_on   = active && ena_s; // R07
	wire logic [1:0] sel_space = start_ok ? acc_space : cur_space;
	wire logic       sel_write = start_ok ? acc_write : cur_write;
	wire logic       drive_on  = pins_on && sel_write;
	logic            space_n [3];

	// one strobe per space, in package order: program, data, io
	for (genvar g = 0; g < 3; g++) begin : g_space
		wire logic hit = pins_on && (sel_space == 2'(g));
		always_ff @(posedge clk) begin
			if (reset)
				space_n[g] <= 1'b1;
			else
				space_n[g] <= !hit; // R12
		end
	end
	assign program_space_strobe_n = space_n[0];
	assign data_space_strobe_n    = space_n[1];
	assign io_space_strobe_n      = space_n[2];

	always_ff @(posedge clk) begin
		if (reset) begin
			ext_addr <= '0;
			ext_data_out <= 16'h0000;
		end else if (start_ok) begin
			ext_addr <= acc_addr; // R11
			ext_data_out <= acc_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			access_strobe_n <= 1'b1;
			read_write <= 1'b1;
			read_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
		end else begin
			access_strobe_n <= !pins_on; // R14
			read_write <= !drive_on; // R13
			read_strobe_n <= !(pins_on && !sel_write); // R15
			write_strobe_n <= !drive_on;
		end
	end

	// decode logic outside may release the bus on this indication
	always_ff @(posedge clk) begin
		if (reset) begin
			ext_data_oe <= 1'b0;
			observe_mode_bus_drive_n <= 1'b1;
		end else begin
			ext_data_oe <= drive_on;
			observe_mode_bus_drive_n <= !(visibility_mode && drive_on); // R09 R10
		end
	end

	// core-side answer, registered
	wire logic capture_rd = finishing && !cur_write;
	always_ff @(posedge clk) begin
		if (reset) begin
			acc_busy <= 1'b0;
			acc_done <= 1'b0;
			acc_rdata <= 16'h0000;
		end else begin
			acc_busy <= active;
			acc_done <= finishing;
			if (capture_rd)
				acc_rdata <= ext_data_in;
		end
	end

	// one pulse per refused data-space request, for the error or interrupt logic
	always_ff @(posedge clk) begin
		if (reset)
			illegal_addr <= 1'b0;
		else
			illegal_addr <= start_bad; // R17
	end

	// boot mode: the level is taken at the first clock after reset release
	always_ff @(posedge clk) begin
		if (reset) begin
			boot_pending <= 1'b1;
			system_control_reg_two <= 16'h0000;
			boot_external <= 1'b0;
			boot_vector <= '0;
		end else begin
			if (boot_pending) begin
				boot_pending <= 1'b0;
				system_control_reg_two[`EBI_SYSCTL2_BOOT_BIT] <= boot_s; // R06
				boot_external <= boot_s; // R04 R05
				boot_vector <= ADDR_W'(`EBI_BOOT_VECTOR); // R04 R05
			end else if (wr_sysctl) begin
				// the boot-mode bit holds the level captured after reset and is not writable
				system_control_reg_two[15:3] <= reg_wdata[15:3];
				system_control_reg_two[1:0] <= reg_wdata[1:0];
			end
		end
	end

	// software registers, status and interrupt
	wire logic [1:0]  events      = {finishing, start_bad};
	wire logic [1:0]  status_clr  = wr_status ? reg_wdata[1:0] : 2'h0;
	// a new event wins over a write-one clear in the same cycle
	wire logic [1:0]  next_status = (status & ~status_clr) | events;
	wire logic [15:0] next_rdata  = reg_read ? rd_mux : 16'h0000;

	always_ff @(posedge clk) begin
		if (reset) begin
			wait_state_config_reg <= `EBI_WSCFG_RESET;
			mask <= 2'(`EBI_MASK_RESET);
		end else begin
			if (wr_wscfg)
				wait_state_config_reg <= reg_wdata;
			if (wr_mask)
				mask <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			status <= 2'h0;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			irq <= |(status & mask);
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			reg_rdata <= 16'h0000;
		else
			reg_rdata <= next_rdata;
	end

endmodule

`default_nettype wire

// ---- design/ebi_pkg.sv ----
package ebi_pkg;
	typedef enum logic [1:0] {
		EBI_IDLE  = 2'h0,
		EBI_SOFT  = 2'h1,
		EBI_READY = 2'h3,
		EBI_END   = 2'h2
	} ebi_state_t;

	typedef enum logic [1:0] {
		EBI_SPACE_PROG = 2'h0,
		EBI_SPACE_DATA = 2'h1,
		EBI_SPACE_IO   = 2'h2
	} ebi_space_t;
endpackage

// ---- design/ebi_regs.svh ----
`ifndef EBI_REGS_SVH
`define EBI_REGS_SVH

// register offsets (word addresses on the plain register port)
`define EBI_WSCFG_ADDR      4'h0
`define EBI_SYSCTL2_ADDR    4'h1
`define EBI_STATUS_ADDR     4'h2
`define EBI_MASK_ADDR       4'h3

// field positions
`define EBI_SYSCTL2_BOOT_BIT 2
`define EBI_ST_ILLEGAL_BIT   0
`define EBI_ST_DONE_BIT      1

// reset values
`define EBI_WSCFG_RESET     16'h0000
`define EBI_MASK_RESET      16'h0000
`define EBI_BOOT_VECTOR     16'h0000

`endif

// ---- sim/ebi_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module ebi_chk (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        acc_req,
	input wire logic        acc_busy,
	input wire logic        acc_done,
	input wire logic        illegal_addr,
	input wire logic        data_space_strobe_n,
	input wire logic        io_space_strobe_n,
	input wire logic        program_space_strobe_n,
	input wire logic        access_strobe_n,
	input wire logic        read_write,
	input wire logic        read_strobe_n,
	input wire logic        write_strobe_n,
	input wire logic        ext_data_oe,
	input wire logic        observe_mode_bus_drive_n,
	input wire logic        reg_write,
	input wire logic [1:0]  acc_space,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata
);
	logic [2:0] ws;
	logic [7:0] bcnt;
	wire logic [2:0] sp_n = {data_space_strobe_n, io_space_strobe_n, program_space_strobe_n};
	// shadow of the soft wait count, so latency checks need no register read
	always_ff @(posedge clk) begin
		if (reset) ws <= 3'h0;
		else if (reg_write && reg_addr == 4'h0) ws <= reg_wdata[2:0];
		bcnt <= (acc_busy && !reset) ? bcnt + 8'h01 : 8'h00;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	strobe_any_a: assert property (access_strobe_n == (&sp_n))
		else $error("access strobe not matching space strobes");
	one_space_a: assert property ($countones(~sp_n) <= 1)
		else $error("more than one space strobe low");
	rw_rest_a: assert property (!read_write |-> !access_strobe_n && read_strobe_n)
		else $error("write qualifier low outside a write");
	write_qual_a: assert property (!write_strobe_n |-> !read_write)
		else $error("write strobe without write qualifier");
	read_strobe_a: assert property (!read_strobe_n |-> read_write && !access_strobe_n)
		else $error("read strobe outside a read cycle");
	illegal_pulse_a: assert property (illegal_addr |=> !illegal_addr)
		else $error("illegal address longer than one cycle");
	illegal_src_a: assert property (illegal_addr |-> $past(acc_req) && $past(acc_space) == 2'h1)
		else $error("illegal address without data request");
	nowait_done_a: assert property ($rose(acc_busy) && ws == 3'h0 |=> acc_done)
		else $error("zero wait access not done at once");
	soft_wait_a: assert property (acc_done |-> bcnt > {5'h00, ws})
		else $error("access shorter than soft wait count");
	vis_drive_a: assert property (!observe_mode_bus_drive_n |-> ext_data_oe)
		else $error("drive indicator low while bus not driven");
	cover property (illegal_addr);
	cover property (acc_done && ws != 3'h0);
	cover property (!observe_mode_bus_drive_n);
endmodule
bind ebi_external_bus_interface ebi_chk u_chk (.clk(clk), .reset(reset), .acc_req(acc_req),
	.acc_busy(acc_busy), .acc_done(acc_done), .illegal_addr(illegal_addr),
	.data_space_strobe_n(data_space_strobe_n), .io_space_strobe_n(io_space_strobe_n),
	.program_space_strobe_n(program_space_strobe_n), .access_strobe_n(access_strobe_n),
	.read_write(read_write), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
	.ext_data_oe(ext_data_oe), .observe_mode_bus_drive_n(observe_mode_bus_drive_n),
	.reg_write(reg_write), .acc_space(acc_space), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
`default_nettype wire

// ---- sim/ebi_external_bus_interface_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ebi_external_bus_interface_tb_top;
	logic clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, acc_req = 1'b0;
	logic acc_write = 1'b0, visibility_mode = 1'b0, boot_memory_select = 1'b1, vis_lo;
	logic ext_interface_on = 1'b1, irq, acc_busy, acc_done, illegal_addr, boot_external;
	logic ready_pin, ext_data_oe, read_write, read_strobe_n, write_strobe_n;
	logic data_space_strobe_n, io_space_strobe_n, program_space_strobe_n, access_strobe_n;
	logic observe_mode_bus_drive_n;
	logic [1:0] acc_space = 2'h0, rr;
	logic [2:0] sp;
	logic [2:0] pat [3] = '{3'h6, 3'h3, 3'h5};
	logic [3:0] reg_addr = 4'h0, stall = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, acc_addr = 16'h0000, acc_wdata = 16'h0000, reg_rdata;
	logic [15:0] acc_rdata, boot_vector, ext_addr, ext_data_in, ext_data_out, ad, dout, v, a;
	int num_errors = 0, cmp_count = 0, scnt = 0, f;
	ebi_external_bus_interface dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .irq, .acc_req, .acc_space, .acc_write, .acc_addr, .acc_wdata,
		.visibility_mode, .acc_busy, .acc_done, .acc_rdata, .illegal_addr, .boot_external,
		.boot_vector, .ready_pin, .boot_memory_select, .ext_interface_on, .ext_addr,
		.ext_data_in, .ext_data_out, .ext_data_oe, .data_space_strobe_n, .io_space_strobe_n,
		.program_space_strobe_n, .access_strobe_n, .read_write, .read_strobe_n,
		.write_strobe_n, .observe_mode_bus_drive_n);
	ebi_mem_model mem (.clk, .access_strobe_n, .read_write, .observe_mode_bus_drive_n,
		.ext_addr, .stall, .ready_pin, .ext_data_in);
	always #5 clk = ~clk;
	// pin monitor: keeps what the bus showed during the last access
	always @(negedge clk) begin
		if (access_strobe_n === 1'b0) begin
			scnt++;
			sp = {data_space_strobe_n, io_space_strobe_n, program_space_strobe_n};
			ad = ext_addr;
			rr = {read_write, read_strobe_n};
			dout = ext_data_out;
			vis_lo |= (observe_mode_bus_drive_n === 1'b0);
		end
	end
	task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, exp, got);
		end
	endtask
	task end_sim;
		if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task wr(input logic [3:0] ra, input logic [15:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= ra;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [3:0] ra);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= ra;
		@(posedge clk);
		reg_read <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
	endtask
	task go(input logic [1:0] s, input logic w, input logic [15:0] xa);
		scnt = 0;
		vis_lo = 1'b0;
		@(posedge clk);
		acc_req <= 1'b1;
		acc_space <= s;
		acc_write <= w;
		acc_addr <= xa;
		acc_wdata <= ~xa;
		@(posedge clk);
		acc_req <= 1'b0;
	endtask
	task acc(input logic [1:0] s, input logic w, input logic [15:0] xa);
		int i;
		go(s, w, xa);
		for (i = 0; i < 200 && acc_done !== 1'b1; i++) @(negedge clk);
		if (i == 200) begin
			num_errors++;
			end_sim;
		end
	endtask
	task rst(input logic b);
		boot_memory_select <= b;
		reset <= 1'b1;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("boot_ext", {15'h0, boot_external}, {15'h0, b});
		chk("boot_vec", boot_vector, 16'h0000);
		rd(4'h1);
		chk("sysctl2", v & 16'h0004, {13'h0, b, 2'h0});
	endtask
	initial begin
		rst(1'b1);
		rd(4'hF);
		chk("unmapped", v, 16'h0000);
		wr(4'h1, 16'h0000);
		rd(4'h1);
		chk("boot_ro", v & 16'h0004, 16'h0004);
		// long stall with no soft wait: the device must not wait for ready
		stall = 4'h8;
		@(posedge clk);
		visibility_mode <= 1'b1;
		for (int s = 0; s < 3; s++) begin
			a = 16'h8001 | (16'h0010 << s);
			acc(s[1:0], 1'b0, a);
			chk("nowait", scnt[15:0], 16'h0001);
			chk("space", {13'h0, sp}, {13'h0, pat[s]});
			chk("addr", ad, a);
			chk("rd_dir", {14'h0, rr}, 16'h0002);
			chk("rdata", acc_rdata, a ^ 16'h5A5A);
			chk("vis_rd", {15'h0, vis_lo}, 16'h0000);
			acc(s[1:0], 1'b1, a);
			chk("wr_dir", {14'h0, rr}, 16'h0001);
			chk("wdata", dout, ~a);
			chk("vis", {15'h0, vis_lo}, 16'h0001);
		end
		wr(4'h0, 16'h0003);
		stall = 4'h0;
		acc(2'h0, 1'b0, 16'h1234);
		f = scnt;
		chk("soft", f[15:0], 16'h0005);
		stall = 4'hC;
		acc(2'h0, 1'b0, 16'h1234);
		chk("ready_ext", {15'h0, scnt > f}, 16'h0001);
		chk("rdata_ws", acc_rdata, 16'h1234 ^ 16'h5A5A);
		// one soft wait: the first ready sample must not see the idle level
		wr(4'h0, 16'h0001);
		stall = 4'h4;
		acc(2'h1, 1'b0, 16'h0F0F);
		chk("ready_one", {15'h0, scnt > 4}, 16'h0001);
		chk("rdata_one", acc_rdata, 16'h0F0F ^ 16'h5A5A);
		@(posedge clk);
		ext_interface_on <= 1'b0;
		repeat (3) @(posedge clk);
		go(2'h1, 1'b0, 16'h0042);
		@(negedge clk);
		chk("illegal", {15'h0, illegal_addr}, 16'h0001);
		go(2'h0, 1'b0, 16'h0042);
		repeat (3) @(negedge clk);
		chk("off_pins", scnt[15:0], 16'h0000);
		chk("irq_mask", {15'h0, irq}, 16'h0000);
		rd(4'h2);
		chk("status", v & 16'h0001, 16'h0001);
		chk("st_done", v & 16'h0002, 16'h0002);
		wr(4'h3, 16'h0001);
		repeat (2) @(negedge clk);
		chk("irq_on", {15'h0, irq}, 16'h0001);
		wr(4'h2, 16'h0001);
		repeat (2) @(negedge clk);
		chk("irq_clr", {15'h0, irq}, 16'h0000);
		@(posedge clk);
		ext_interface_on <= 1'b1;
		rst(1'b0);
		end_sim;
	end
endmodule
`default_nettype wire

// ---- sim/ebi_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ebi_mem_model (
	input  wire logic        clk,
	input  wire logic        access_strobe_n,
	input  wire logic        read_write,
	input  wire logic        observe_mode_bus_drive_n,
	input  wire logic [15:0] ext_addr,
	input  wire logic [3:0]  stall,
	output logic             ready_pin,
	output logic      [15:0] ext_data_in
);
	logic [3:0]  cnt = 4'h0;
	logic [15:0] last = 16'h0000;
	wire logic   rd_sel = !access_strobe_n && read_write && observe_mode_bus_drive_n;
	always_ff @(posedge clk) begin
		cnt <= access_strobe_n ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
		last <= ext_data_in;
	end
	// slow device holds ready low for stall cycles; the pin idles pulled high
	assign ready_pin = access_strobe_n || cnt >= stall;
	// bus released outside own reads, so stale data never looks valid
	assign ext_data_in = rd_sel ? (ext_addr ^ 16'h5A5A) : ~last;
endmodule
`default_nettype wire
